// ==== gear_home_pkg.sv ====
// Functional notes
// - Gear numerator holds 1 to 10,000,000, reset value 1.
// - Gear denominator holds 1 to 10,000,000, reset value 1.
// - Pulses are command units times numerator over denominator.
// - Numerator and denominator both 1 give one pulse per command unit.
// - New gear values take effect only at power-up or unit reset; SRST restores 1, only UNIT_RESET latches writes.
// - Seven search types: inputs used, limit reversal.
// - Type 0 starts at fast speed in search direction.
// - First proximity change gives approach speed.
// - After second proximity change, first Z pulse gives creep.
// - Offset distance past the Z point is the origin.
// - Reference-only type: approach speed, creep on reference edge, then offset.
// - Type 2: fast, approach, creep on reference after second change.
// - Phase-Z-only type: approach speed, creep on first Z pulse, then offset.
// - Type 4: type 0 plus search-side limit reversal.
// - Type 5: type 1 plus search-side limit reversal.
// - Type 6: type 2 plus search-side limit reversal.
// - Mode values 0 to 6 select the seven search types in order.
// - Function bit 0 gives direction: 0 positive, 1 negative.
// - Function bit 1 is proximity active level, bit 2 reference active edge.
package gear_home_pkg;

    // ****************************************
    // Gear ratio
    // ****************************************
    localparam logic [31:0] GEAR_MIN       = 32'h0000_0001;
    localparam logic [31:0] GEAR_MAX       = 32'h0098_9680;
    localparam logic [31:0] GEAR_RESET     = 32'h0000_0001;
    localparam int          GEAR_W         = 24;
    localparam int          DIV_STEPS      = 64;

    // ****************************************
    // Parameter port selectors
    // ****************************************
    localparam logic [1:0]  SEL_NUM        = 2'h0;
    localparam logic [1:0]  SEL_DEN        = 2'h1;
    localparam logic [1:0]  SEL_NUM_ACTIVE = 2'h2;
    localparam logic [1:0]  SEL_DEN_ACTIVE = 2'h3;

    // ****************************************
    // Origin search
    // ****************************************
    localparam int          FUNC_DIR_BIT   = 0;
    localparam int          FUNC_PROX_BIT  = 1;
    localparam int          FUNC_REF_BIT   = 2;
    localparam int          SPEED_W        = 18;
    localparam logic [2:0]  TYPE_PROX_Z    = 3'h0;
    localparam logic [2:0]  TYPE_REF       = 3'h1;
    localparam logic [2:0]  TYPE_PROX_REF  = 3'h2;
    localparam logic [2:0]  TYPE_Z         = 3'h3;
    localparam logic [2:0]  TYPE_PROX_Z_RV = 3'h4;
    localparam logic [2:0]  TYPE_REF_RV    = 3'h5;
    localparam logic [2:0]  TYPE_PROX_R_RV = 3'h6;
    localparam logic [31:0] ORIGIN_VALUE   = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FAST,
        ST_APPROACH,
        ST_WAIT_TRIG,
        ST_OFFSET
    } stage_t;

endpackage : gear_home_pkg

// ==== gear_scaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module gear_scaler
    import gear_home_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic [GEAR_W-1:0]  num,
    input  wire logic [GEAR_W-1:0]  den,
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire logic signed [31:0] in_pos,
    output logic                    out_valid,
    output logic [31:0]             out_pos
);

    typedef struct packed {
        logic            busy;
        logic            neg;
        logic [6:0]      cnt;
        logic [63:0]     dvd;
        logic [GEAR_W:0] rem;
        logic            valid;
        logic [31:0]     pos;
    } scale_st_t;

    scale_st_t st_r;
    scale_st_t st_nxt;

    logic [31:0]     mag;
    logic [GEAR_W:0] trial;

    assign in_ready  = !st_r.busy;
    assign out_valid = st_r.valid;
    assign out_pos   = st_r.pos;

    // ****************************************
    // Multiply, then restoring divide
    // ****************************************
    always_comb begin
        st_nxt       = st_r;
        st_nxt.valid = 1'b0;
        mag          = in_pos[31] ? 32'(-in_pos) : 32'(in_pos);
        trial        = {st_r.rem[GEAR_W-1:0], st_r.dvd[63]};
        if (!st_r.busy && in_valid) begin
            if (num == GEAR_W'(GEAR_MIN) && den == GEAR_W'(GEAR_MIN)) begin
                st_nxt.valid = 1'b1;
                st_nxt.pos   = in_pos;
            end else begin
                st_nxt.busy = 1'b1;
                st_nxt.neg  = in_pos[31];
                st_nxt.cnt  = 7'h00;
                st_nxt.dvd  = 64'(mag) * 64'(num);
                st_nxt.rem  = '0;
            end
        end else if (st_r.busy) begin
            st_nxt.dvd = {st_r.dvd[62:0], 1'b0};
            st_nxt.rem = trial;
            if (trial >= {1'b0, den}) begin
                st_nxt.rem    = trial - {1'b0, den};
                st_nxt.dvd[0] = 1'b1;
            end
            st_nxt.cnt = st_r.cnt + 7'h01;
            if (st_r.cnt == 7'(DIV_STEPS - 1)) begin
                st_nxt.busy  = 1'b0;
                st_nxt.valid = 1'b1;
                // Truncates toward zero; keeps only the low 32 bits of the 64-bit quotient
                st_nxt.pos   = st_r.neg ? 32'(-st_nxt.dvd[31:0]) : st_nxt.dvd[31:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : gear_scaler
`default_nettype wire

// ==== gear_home_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module gear_home_ctrl
    import gear_home_pkg::*;
(
    input  wire logic               CLOCK,
    input  wire logic               SRST,
    // ****************************************
    // Parameter access
    // ****************************************
    input  wire logic               PARAM_WE,
    input  wire logic [1:0]         PARAM_SEL,
    input  wire logic [31:0]        PARAM_WDATA,
    output logic [31:0]             PARAM_RDATA,
    input  wire logic               UNIT_RESET,
    // ****************************************
    // Position commands
    // ****************************************
    input  wire logic               CMD_VALID,
    output logic                    CMD_READY,
    input  wire logic signed [31:0] CMD_POS,
    output logic                    PULSE_VALID,
    output logic [31:0]             PULSE_POS,
    // ****************************************
    // Origin search settings
    // ****************************************
    input  wire logic [2:0]         SEARCH_TYPE_SELECT,
    input  wire logic [2:0]         SEARCH_FUNCTION_SELECT,
    input  wire logic [SPEED_W-1:0] SEARCH_FAST_SPEED,
    input  wire logic [SPEED_W-1:0] SEARCH_APPROACH_SPEED,
    input  wire logic [SPEED_W-1:0] SEARCH_CREEP_SPEED,
    input  wire logic [31:0]        ORIGIN_OFFSET_DISTANCE,
    input  wire logic               HOME_START,
    // ****************************************
    // Machine inputs
    // ****************************************
    input  wire logic               HOME_PROXIMITY_INPUT,
    input  wire logic               REFERENCE_INPUT,
    input  wire logic               PHASE_Z_INPUT,
    input  wire logic               POS_LIMIT_INPUT,
    input  wire logic               NEG_LIMIT_INPUT,
    input  wire logic               ENC_STEP,
    input  wire logic               ENC_DIR_NEG,
    // ****************************************
    // Motion outputs
    // ****************************************
    output logic [SPEED_W-1:0]      SPEED_OUT,
    output logic                    DIR_NEG_OUT,
    output logic                    HOME_BUSY,
    output logic                    HOME_DONE,
    output logic                    ORIGIN_SET,
    output logic [31:0]             PRESENT_POS
);

    typedef struct packed {
        logic [31:0]        gear_num_value;
        logic [31:0]        gear_den_value;
        logic [31:0]        num_active;
        logic [31:0]        den_active;
        logic [31:0]        rdata;
        logic               prox_q;
        logic               prox_p;
        logic               ref_q;
        logic               ref_p;
        logic               z_q;
        logic               z_p;
        logic               plim_q;
        logic               nlim_q;
        logic               step_q;
        logic               step_neg_q;
        stage_t             stage;
        logic [2:0]         stype;
        logic [2:0]         func;
        logic               dir_neg;
        logic               reversed;
        logic [SPEED_W-1:0] speed;
        logic [31:0]        pos;
        logic [31:0]        mark;
        logic               homed;
        logic               done;
    } ctrl_st_t;

    ctrl_st_t st_r;
    ctrl_st_t st_nxt;

    logic prox_on_edge;
    logic prox_off_edge;
    logic ref_edge;
    logic z_edge;
    logic trigger;
    logic use_z;
    logic reverses;
    logic side_limit;
    logic [31:0] travelled;
    logic [31:0] pos_step;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic edge_to(input logic cur, input logic prev, input logic lvl);
        edge_to = (cur == lvl) && (prev != lvl);
    endfunction : edge_to

    function automatic logic in_range(input logic [31:0] v);
        in_range = (v >= GEAR_MIN) && (v <= GEAR_MAX);
    endfunction : in_range

    function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] d;
        d        = a - b;
        abs_diff = d[31] ? 32'(-d) : d;
    endfunction : abs_diff

    function automatic logic three_stage(input logic [2:0] t);
        three_stage = (t == TYPE_PROX_Z) || (t == TYPE_PROX_REF) || (t == TYPE_PROX_Z_RV)
                   || (t == TYPE_PROX_R_RV);
    endfunction : three_stage

    // ****************************************
    // Gear scaling
    // ****************************************
    gear_scaler u_scaler (
        .clk       (CLOCK),
        .srst      (SRST),
        .num       (st_r.num_active[GEAR_W-1:0]),
        .den       (st_r.den_active[GEAR_W-1:0]),
        .in_valid  (CMD_VALID),
        .in_ready  (CMD_READY),
        .in_pos    (CMD_POS),
        .out_valid (PULSE_VALID),
        .out_pos   (PULSE_POS)
    );

    // ****************************************
    // Input event decode
    // ****************************************
    always_comb begin
        prox_on_edge  = edge_to(st_r.prox_q, st_r.prox_p, st_r.func[FUNC_PROX_BIT]);
        prox_off_edge = edge_to(st_r.prox_q, st_r.prox_p, !st_r.func[FUNC_PROX_BIT]);
        ref_edge      = edge_to(st_r.ref_q, st_r.ref_p, st_r.func[FUNC_REF_BIT]);
        z_edge        = edge_to(st_r.z_q, st_r.z_p, 1'b1);
        use_z         = (st_r.stype == TYPE_PROX_Z) || (st_r.stype == TYPE_Z)
                     || (st_r.stype == TYPE_PROX_Z_RV);
        reverses      = (st_r.stype >= TYPE_PROX_Z_RV);
        trigger       = use_z ? z_edge : ref_edge;
        side_limit    = st_r.dir_neg ? st_r.nlim_q : st_r.plim_q;
        travelled     = abs_diff(st_r.pos, st_r.mark);
        pos_step      = st_r.step_neg_q ? 32'hFFFF_FFFF : 32'h0000_0001;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;

        st_nxt.prox_q     = HOME_PROXIMITY_INPUT;
        st_nxt.prox_p     = st_r.prox_q;
        st_nxt.ref_q      = REFERENCE_INPUT;
        st_nxt.ref_p      = st_r.ref_q;
        st_nxt.z_q        = PHASE_Z_INPUT;
        st_nxt.z_p        = st_r.z_q;
        st_nxt.plim_q     = POS_LIMIT_INPUT;
        st_nxt.nlim_q     = NEG_LIMIT_INPUT;
        st_nxt.step_q     = ENC_STEP;
        st_nxt.step_neg_q = ENC_DIR_NEG;

        if (PARAM_WE && PARAM_SEL == SEL_NUM && in_range(PARAM_WDATA)) begin
            st_nxt.gear_num_value = PARAM_WDATA;
        end
        if (PARAM_WE && PARAM_SEL == SEL_DEN && in_range(PARAM_WDATA)) begin
            st_nxt.gear_den_value = PARAM_WDATA;
        end
        // Ratio latched only on unit reset
        if (UNIT_RESET) begin
            st_nxt.num_active = st_r.gear_num_value;
            st_nxt.den_active = st_r.gear_den_value;
        end

        case (PARAM_SEL)
            SEL_NUM:        st_nxt.rdata = st_r.gear_num_value;
            SEL_DEN:        st_nxt.rdata = st_r.gear_den_value;
            SEL_NUM_ACTIVE: st_nxt.rdata = st_r.num_active;
            default:        st_nxt.rdata = st_r.den_active;
        endcase

        if (st_r.step_q) begin
            st_nxt.pos = st_r.pos + pos_step;
        end

        if (st_r.stage != ST_IDLE && st_r.stage != ST_OFFSET && reverses
                && !st_r.reversed && side_limit) begin
            st_nxt.dir_neg  = !st_r.dir_neg;
            st_nxt.reversed = 1'b1;
        end

        case (st_r.stage)
            ST_IDLE: begin
                st_nxt.speed = '0;
                if (HOME_START) begin
                    st_nxt.stype    = SEARCH_TYPE_SELECT;
                    st_nxt.func     = SEARCH_FUNCTION_SELECT;
                    st_nxt.dir_neg  = SEARCH_FUNCTION_SELECT[FUNC_DIR_BIT];
                    st_nxt.reversed = 1'b0;
                    st_nxt.homed    = 1'b0;
                    if (three_stage(SEARCH_TYPE_SELECT)) begin
                        st_nxt.stage = ST_FAST;
                        st_nxt.speed = SEARCH_FAST_SPEED;
                    end else if (SEARCH_TYPE_SELECT <= TYPE_PROX_R_RV) begin
                        st_nxt.stage = ST_WAIT_TRIG;
                        st_nxt.speed = SEARCH_APPROACH_SPEED;
                    end
                end
            end
            ST_FAST: begin
                if (prox_on_edge) begin
                    st_nxt.stage = ST_APPROACH;
                    st_nxt.speed = SEARCH_APPROACH_SPEED;
                end
            end
            ST_APPROACH: begin
                if (prox_off_edge) begin
                    st_nxt.stage = ST_WAIT_TRIG;
                end
            end
            ST_WAIT_TRIG: begin
                // Z or reference edge drops to creep
                if (trigger) begin
                    st_nxt.stage = ST_OFFSET;
                    st_nxt.speed = SEARCH_CREEP_SPEED;
                    st_nxt.mark  = st_nxt.pos;
                end
            end
            ST_OFFSET: begin
                if (travelled >= ORIGIN_OFFSET_DISTANCE) begin
                    st_nxt.pos   = ORIGIN_VALUE;
                    st_nxt.homed = 1'b1;
                    st_nxt.done  = 1'b1;
                    st_nxt.speed = '0;
                    st_nxt.stage = ST_IDLE;
                end
            end
            default: begin
                st_nxt.stage = ST_IDLE;
                st_nxt.speed = '0;
            end
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            st_r                <= '0;
            st_r.gear_num_value <= GEAR_RESET;
            st_r.gear_den_value <= GEAR_RESET;
            st_r.num_active     <= GEAR_RESET;
            st_r.den_active     <= GEAR_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign PARAM_RDATA = st_r.rdata;
    assign SPEED_OUT   = st_r.speed;
    assign DIR_NEG_OUT = st_r.dir_neg;
    assign HOME_BUSY   = (st_r.stage != ST_IDLE);
    assign HOME_DONE   = st_r.done;
    assign ORIGIN_SET  = st_r.homed;
    assign PRESENT_POS = st_r.pos;

endmodule : gear_home_ctrl
`default_nettype wire

// ==== gear_home_checker_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module gear_home_checker
    import gear_home_pkg::*;
(
    input wire logic               CLOCK,
    input wire logic               SRST,
    input wire logic               PARAM_WE,
    input wire logic [1:0]         PARAM_SEL,
    input wire logic [31:0]        PARAM_WDATA,
    input wire logic [31:0]        PARAM_RDATA,
    input wire logic               UNIT_RESET,
    input wire logic               CMD_VALID,
    input wire logic               CMD_READY,
    input wire logic               PULSE_VALID,
    input wire logic [2:0]         SEARCH_TYPE_SELECT,
    input wire logic [2:0]         SEARCH_FUNCTION_SELECT,
    input wire logic [SPEED_W-1:0] SEARCH_FAST_SPEED,
    input wire logic [SPEED_W-1:0] SEARCH_APPROACH_SPEED,
    input wire logic               HOME_START,
    input wire logic [SPEED_W-1:0] SPEED_OUT,
    input wire logic               DIR_NEG_OUT,
    input wire logic               HOME_BUSY,
    input wire logic               HOME_DONE,
    input wire logic               ORIGIN_SET,
    input wire logic [31:0]        PRESENT_POS
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);
    logic [1:0] quiet_r;
    logic       go;
    // ****************************************
    // Helper logic
    // ****************************************
    // Readback may only move two edges after a latch
    always_ff @(posedge CLOCK) begin
        if (SRST || UNIT_RESET || PARAM_SEL != SEL_NUM_ACTIVE) begin
            quiet_r <= 2'h0;
        end else if (quiet_r != 2'h3) begin
            quiet_r <= quiet_r + 2'h1;
        end
    end
    assign go = HOME_START && !HOME_BUSY && SEARCH_TYPE_SELECT != 3'h7;
    property p_num_write;
        PARAM_WE && PARAM_SEL == SEL_NUM && PARAM_WDATA >= GEAR_MIN && PARAM_WDATA <= GEAR_MAX
            ##1 PARAM_SEL == SEL_NUM |=> PARAM_RDATA == $past(PARAM_WDATA, 2);
    endproperty
    a_num_write: assert property (p_num_write) else $error("numerator readback");
    property p_latch_hold;
        quiet_r == 2'h3 |-> $stable(PARAM_RDATA);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("ratio moved");
    property p_cmd_answer;
        CMD_VALID && CMD_READY |=> ##[0:64] PULSE_VALID;
    endproperty
    a_cmd_answer: assert property (p_cmd_answer) else $error("no scaled result");
    property p_cmd_busy;
        CMD_VALID && CMD_READY ##1 !PULSE_VALID |-> !CMD_READY;
    endproperty
    a_cmd_busy: assert property (p_cmd_busy) else $error("ready while dividing");
    property p_start_speed;
        go |=> HOME_BUSY && SPEED_OUT == (SEARCH_TYPE_SELECT[0] ? SEARCH_APPROACH_SPEED
                                                                 : SEARCH_FAST_SPEED);
    endproperty
    a_start_speed: assert property (p_start_speed) else $error("start speed");
    property p_start_dir;
        go |=> DIR_NEG_OUT == $past(SEARCH_FUNCTION_SELECT[FUNC_DIR_BIT]);
    endproperty
    a_start_dir: assert property (p_start_dir) else $error("start direction");
    property p_type_bad;
        HOME_START && !HOME_BUSY && SEARCH_TYPE_SELECT == 3'h7 |=> !HOME_BUSY;
    endproperty
    a_type_bad: assert property (p_type_bad) else $error("bad type started");
    property p_done_origin;
        HOME_DONE |-> ORIGIN_SET && PRESENT_POS == ORIGIN_VALUE && !HOME_BUSY && SPEED_OUT == '0;
    endproperty
    a_done_origin: assert property (p_done_origin) else $error("origin not set");
    property p_done_end;
        HOME_BUSY ##1 !HOME_BUSY |-> HOME_DONE;
    endproperty
    a_done_end: assert property (p_done_end) else $error("search ended silently");
    c_done: cover property (HOME_DONE);
    c_b2b: cover property (PULSE_VALID && CMD_VALID && CMD_READY);
    c_latch: cover property (UNIT_RESET);
endmodule : gear_home_checker
bind gear_home_ctrl gear_home_checker i_gear_home_checker (.*);
`default_nettype wire

// ==== axis_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module axis_model (
    input  wire logic               clk,
    input  wire logic               load,
    input  wire logic signed [31:0] load_pos,
    input  wire logic               slow,
    input  wire logic               prox_inv,
    input  wire logic [17:0]        speed,
    input  wire logic               dir_neg,
    output logic                    step,
    output logic                    step_neg,
    output logic                    prox,
    output logic                    refl,
    output logic                    zpulse,
    output logic                    plim,
    output logic                    nlim,
    output logic signed [31:0]      pos
);
    logic [1:0]  div_r;
    logic [31:0] mag;
    // ****************************************
    // Axis with marks mirrored about zero
    // ****************************************
    assign mag    = pos < 0 ? -pos : pos;
    assign prox   = (mag >= 32'h28 && mag < 32'h3C) ^ prox_inv;
    assign refl   = mag[4];
    assign zpulse = mag % 32'h19 == 32'h0;
    assign plim   = pos >= 32'sh64;
    assign nlim   = pos <= -32'sh64;
    // Slow mode shows the design a lazy encoder
    always_ff @(posedge clk) begin
        step <= 1'b0;
        div_r <= div_r + 2'h1;
        if (load) begin
            pos      <= load_pos;
            div_r    <= 2'h0;
            step_neg <= 1'b0;
        end else if (speed != 18'h0 && (slow ? div_r == 2'h0 : !div_r[0])) begin
            step     <= 1'b1;
            step_neg <= dir_neg;
            pos      <= dir_neg ? pos - 32'sh1 : pos + 32'sh1;
        end
    end
endmodule : axis_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import gear_home_pkg::*;
    localparam logic [17:0] FAST = 18'h00030;
    localparam logic [17:0] APPR = 18'h00020;
    localparam logic [17:0] CREEP = 18'h00010;
    logic               CLOCK = 1'b0;
    logic               SRST = 1'b1;
    logic               PARAM_WE = 1'b0;
    logic [1:0]         PARAM_SEL = 2'h0;
    logic [31:0]        PARAM_WDATA = 32'h0;
    logic [31:0]        PARAM_RDATA, PULSE_POS, PRESENT_POS;
    logic               UNIT_RESET = 1'b0;
    logic               CMD_VALID = 1'b0;
    logic signed [31:0] CMD_POS = 32'sh0;
    logic [2:0]         SEARCH_TYPE_SELECT = 3'h0;
    logic [2:0]         SEARCH_FUNCTION_SELECT = 3'h0;
    logic [31:0]        ORIGIN_OFFSET_DISTANCE = 32'h0;
    logic               HOME_START = 1'b0;
    logic               CMD_READY, PULSE_VALID, HOME_PROXIMITY_INPUT, REFERENCE_INPUT;
    logic               PHASE_Z_INPUT, POS_LIMIT_INPUT, NEG_LIMIT_INPUT, ENC_STEP, ENC_DIR_NEG;
    logic [SPEED_W-1:0] SPEED_OUT;
    logic               DIR_NEG_OUT, HOME_BUSY, HOME_DONE, ORIGIN_SET;
    logic               load = 1'b1, slow = 1'b0, pinv = 1'b0;
    logic signed [31:0] load_pos = 32'sh3, apos;
    int                 n_fail = 0, n_checks = 0;
    always #2.5 CLOCK = ~CLOCK;
    gear_home_ctrl i_gear_home_ctrl (.CLOCK, .SRST, .PARAM_WE, .PARAM_SEL, .PARAM_WDATA,
        .PARAM_RDATA, .UNIT_RESET, .CMD_VALID, .CMD_READY, .CMD_POS, .PULSE_VALID, .PULSE_POS,
        .SEARCH_TYPE_SELECT, .SEARCH_FUNCTION_SELECT, .SEARCH_FAST_SPEED(FAST),
        .SEARCH_APPROACH_SPEED(APPR), .SEARCH_CREEP_SPEED(CREEP), .ORIGIN_OFFSET_DISTANCE,
        .HOME_START, .HOME_PROXIMITY_INPUT, .REFERENCE_INPUT, .PHASE_Z_INPUT, .POS_LIMIT_INPUT,
        .NEG_LIMIT_INPUT, .ENC_STEP, .ENC_DIR_NEG, .SPEED_OUT, .DIR_NEG_OUT, .HOME_BUSY,
        .HOME_DONE, .ORIGIN_SET, .PRESENT_POS);
    axis_model i_axis_model (.clk(CLOCK), .load(load), .load_pos(load_pos), .slow(slow),
        .prox_inv(pinv), .speed(SPEED_OUT), .dir_neg(DIR_NEG_OUT), .step(ENC_STEP),
        .step_neg(ENC_DIR_NEG), .prox(HOME_PROXIMITY_INPUT), .refl(REFERENCE_INPUT),
        .zpulse(PHASE_Z_INPUT), .plim(POS_LIMIT_INPUT), .nlim(NEG_LIMIT_INPUT), .pos(apos));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic tick;
        @(posedge CLOCK);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out;
        if (n_fail == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic wr(input logic [1:0] sel, input logic [31:0] val);
        PARAM_WE = 1'b1;
        PARAM_SEL = sel;
        PARAM_WDATA = val;
        tick;
        PARAM_WE = 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [1:0] sel, input logic [31:0] exp);
        PARAM_SEL = sel;
        tick;
        chk(PARAM_RDATA, exp);
    endtask : rd_chk
    task automatic cmd(input logic signed [31:0] cpos, input logic [31:0] exp, input int lat);
        int n = 0;
        CMD_VALID = 1'b1;
        CMD_POS = cpos;
        tick;
        CMD_VALID = 1'b0;
        while (PULSE_VALID !== 1'b1 && n < 100) begin
            tick;
            n++;
        end
        chk(PULSE_POS, exp);
        chk(n, lat);
    endtask : cmd
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic gear_check;
        rd_chk(SEL_NUM, GEAR_RESET);
        rd_chk(SEL_DEN_ACTIVE, GEAR_RESET);
        cmd(-32'sh7, -32'sh7, 0);
        wr(SEL_NUM, GEAR_MAX);
        rd_chk(SEL_NUM, GEAR_MAX);
        wr(SEL_NUM, 32'h0);
        wr(SEL_NUM, GEAR_MAX + 32'h1);
        rd_chk(SEL_NUM, GEAR_MAX);
        wr(SEL_DEN, GEAR_MAX);
        rd_chk(SEL_DEN, GEAR_MAX);
        wr(SEL_NUM, 32'h3);
        wr(SEL_DEN, 32'h2);
        rd_chk(SEL_NUM_ACTIVE, GEAR_RESET);
        cmd(32'sh9, 32'h9, 0);
        UNIT_RESET = 1'b1;
        tick;
        UNIT_RESET = 1'b0;
        rd_chk(SEL_NUM_ACTIVE, 32'h3);
        rd_chk(SEL_DEN_ACTIVE, 32'h2);
        cmd(-32'shA, -32'shF, 64);
        cmd(32'sh7, 32'hA, 64);
    endtask : gear_check
    task automatic srch(input logic [2:0] typ, input logic [2:0] fsel, input logic inv,
                        input logic sl, input logic signed [31:0] start,
                        input logic signed [31:0] trig, input logic signed [31:0] off);
        logic [31:0]        hist = 32'h0;
        logic [17:0]        last = 18'h0;
        logic               dir0;
        logic signed [31:0] d;
        int                 flips = 0, n = 0;
        load = 1'b1;
        load_pos = start;
        pinv = inv;
        slow = sl;
        SEARCH_TYPE_SELECT = typ;
        SEARCH_FUNCTION_SELECT = fsel;
        ORIGIN_OFFSET_DISTANCE = off;
        // Let the moved marks pass the input samplers first
        repeat (4) tick;
        load = 1'b0;
        HOME_START = 1'b1;
        tick;
        HOME_START = 1'b0;
        chk(ORIGIN_SET, 32'h0);
        dir0 = DIR_NEG_OUT;
        while (HOME_DONE !== 1'b1 && n < 4000) begin
            if (SPEED_OUT !== last) begin
                hist = {hist[23:0], SPEED_OUT[7:0]};
                last = SPEED_OUT;
            end
            if (DIR_NEG_OUT !== dir0) begin
                flips++;
                dir0 = DIR_NEG_OUT;
            end
            tick;
            n++;
        end
        d = apos - trig;
        d = d < 0 ? -d : d;
        chk(PRESENT_POS, ORIGIN_VALUE);
        chk(ORIGIN_SET, 32'h1);
        chk(hist, typ[0] ? 32'h2010 : 32'h302010);
        chk(flips, typ[2]);
        chk(d >= off && d <= off + 4, 32'h1);
    endtask : srch
    task automatic bad_type;
        SEARCH_TYPE_SELECT = 3'h7;
        HOME_START = 1'b1;
        tick;
        HOME_START = 1'b0;
        tick;
        chk(HOME_BUSY, 32'h0);
        chk(SPEED_OUT, 32'h0);
    endtask : bad_type
    initial begin
        #200000;
        n_fail++;
        close_out;
    end
    initial begin
        repeat (4) @(posedge CLOCK);
        #1;
        SRST = 1'b0;
        gear_check;
        srch(TYPE_PROX_Z, 3'h0, 1'b1, 1'b0, 32'sh3, 32'sh4B, 32'shA);
        srch(TYPE_REF, 3'h6, 1'b0, 1'b1, 32'sh3, 32'sh10, 32'shA);
        srch(TYPE_PROX_REF, 3'h2, 1'b0, 1'b0, 32'sh3, 32'sh40, 32'shA);
        srch(TYPE_Z, 3'h2, 1'b0, 1'b0, 32'sh3, 32'sh19, 32'sh1);
        srch(TYPE_PROX_Z_RV, 3'h2, 1'b0, 1'b0, 32'sh50, 32'sh19, 32'shA);
        srch(TYPE_REF_RV, 3'h6, 1'b0, 1'b0, 32'sh50, 32'sh5F, 32'shA);
        srch(TYPE_PROX_R_RV, 3'h7, 1'b0, 1'b0, -32'sh50, -32'sh1F, 32'shA);
        bad_type;
        close_out;
    end
endmodule : testbench
`default_nettype wire
